// file: temp_alarm.sv
// Purpose: Limit comparison and alarm pins of a two-channel temperature
//          sensor, with an AXI4-Lite register slave.
// Assumes: Conversion results arrive as one-cycle strobes on aclk.
// Notes:   Alarm pins are open drain; an enable high pulls the pin low.
// Function
// - Answer alert response only while alert active.
// - Response address LSB marks high or low cause.
// - Arbitration win releases alert; loss keeps it.
// - Critical alarm low outside critical range always.
// - Critical release needs range less hysteresis, 10C.
// - Config bit 5 picks alert or second critical.
// - Alert mode: pin low on high/low violation.
// - Alert needs one to four consecutive violations.
// - Open remote sensor also asserts alert.
// - Config bit 7 masks the alert.
// - Response clears alert only if cause gone.
// - Diode fault keeps last valid remote result.
// - Diode fault sets status bit 2, alert.
`timescale 1ns/100ps
module temp_alarm
  import temp_alarm_pkg::*;
#(
  parameter logic [6:0] slave_addr = slave_addr_reset
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Conversion results.
  input  wire logic        conv_done,
  input  wire logic [7:0]  local_temp,
  input  wire logic [7:0]  remote_temp,
  input  wire logic        diode_fault,
  // Alert response command from the bus engine.
  input  wire logic        alert_cmd,
  input  wire logic        arb_lost,
  input  wire logic        alert_cmd_end,
  output logic             alert_ack,
  output logic [7:0]       alert_addr_byte,
  // Alarm pins, open drain.
  input  wire logic        critical_alarm_in,
  output logic             critical_alarm_out_oe,
  input  wire logic        second_alarm_pin_in,
  output logic             second_alarm_pin_oe,
  // Interrupt.
  output logic             irq
);

  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               aw_held;
    logic               w_held;
    logic [7:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic [7:0]         ctrl;
    logic [st_width-1:0] status;
    logic [st_width-1:0] mask;
    logic [7:0]         local_high;
    logic [7:0]         local_low;
    logic [7:0]         remote_high;
    logic [7:0]         remote_low;
    logic [7:0]         local_crit;
    logic [7:0]         remote_crit;
    logic [7:0]         hyst;
    logic [1:0]         consec;
    logic [7:0]         local_res;
    logic [7:0]         remote_res;
    logic [2:0]         local_cnt;
    logic [2:0]         remote_cnt;
    logic               crit;
    logic               crit2;
    logic               alert;
    logic               high_cause;
    logic               alert_ack;
    logic [7:0]         addr_byte;
    logic               pend;
    logic               irq;
    logic [1:0]         crit_sync;
    logic [1:0]         sec_sync;
  } state_t;

  state_t s;
  state_t next_s;

  // Signed comparison helpers used for every channel.
  function automatic logic above(input logic [7:0] t, input logic [7:0] l);
    above = $signed(t) >= $signed(l);
  endfunction

  function automatic logic below(input logic [7:0] t, input logic [7:0] l);
    below = $signed(t) < $signed(l);
  endfunction

  // Byte-enabled merge of a bus write into an 8-bit register.
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] st);
    merge = st[0] ? d[7:0] : old;
  endfunction

  logic       lh;
  logic       ll;
  logic       rh;
  logic       rl;
  logic       viol_l;
  logic       viol_r;
  logic       crit_out;
  logic       crit_in;
  logic       crit2_out;
  logic       crit2_in;
  logic [2:0] need;
  logic       do_write;
  logic [7:0] lt_new;
  logic [7:0] rt_new;
  logic [8:0] lc_up;
  logic [8:0] rc_up;
  logic [8:0] lc_dn;
  logic [8:0] rc_dn;
  logic [st_width-1:0] st_set;

  always_comb begin
    next_s = s;
    need = {1'b0, s.consec} + 3'h1;
    lt_new = local_temp;
    rt_new = diode_fault ? s.remote_res : remote_temp;
    lh = above(lt_new, s.local_high);
    ll = below(lt_new, s.local_low);
    rh = above(rt_new, s.remote_high);
    rl = below(rt_new, s.remote_low);
    viol_l = lh | ll;
    viol_r = rh | rl;
    // Critical range is high-side only at the crit limit; release needs
    // the result to fall below the limit minus hysteresis.
    lc_up = {lt_new[7], lt_new} - {s.local_crit[7], s.local_crit};
    rc_up = {rt_new[7], rt_new} - {s.remote_crit[7], s.remote_crit};
    lc_dn = {lt_new[7], lt_new} + {s.hyst[7], s.hyst}
            - {s.local_crit[7], s.local_crit};
    rc_dn = {rt_new[7], rt_new} + {s.hyst[7], s.hyst}
            - {s.remote_crit[7], s.remote_crit};
    crit_out = !lc_up[8] | !rc_up[8];
    crit_in = lc_dn[8] & rc_dn[8];
    crit2_out = viol_l | viol_r;
    crit2_in = !viol_l & !viol_r;
    st_set = conv_done ? {crit_out, rl, rh, diode_fault, ll, lh}
                       : '0;

    // Pin inputs pass two flip-flops before use.
    next_s.crit_sync = {s.crit_sync[0], critical_alarm_in};
    next_s.sec_sync = {s.sec_sync[0], second_alarm_pin_in};

    // Conversion evaluation.
    if (conv_done) begin
      next_s.local_res = lt_new;
      next_s.remote_res = rt_new;
      if (viol_l) begin
        next_s.local_cnt = (s.local_cnt < 3'h4) ? s.local_cnt + 3'h1
                                                : s.local_cnt;
      end else begin
        next_s.local_cnt = 3'h0;
      end
      if (viol_r) begin
        next_s.remote_cnt = (s.remote_cnt < 3'h4) ? s.remote_cnt + 3'h1
                                                  : s.remote_cnt;
      end else begin
        next_s.remote_cnt = 3'h0;
      end
      if (crit_out) begin
        next_s.crit = 1'b1;
      end else if (crit_in) begin
        next_s.crit = 1'b0;
      end
      if (crit2_out) begin
        next_s.crit2 = 1'b1;
      end else if (crit2_in) begin
        next_s.crit2 = 1'b0;
      end
      if (lh) next_s.status[st_local_high] = 1'b1;
      if (ll) next_s.status[st_local_low] = 1'b1;
      if (rh) next_s.status[st_remote_high] = 1'b1;
      if (rl) next_s.status[st_remote_low] = 1'b1;
      if (crit_out) next_s.status[st_crit] = 1'b1;
      if (diode_fault) next_s.status[st_open_diode] = 1'b1;
      // Alert sets after the programmed run of violations, or on fault.
      if ((viol_l && (s.local_cnt + 3'h1 >= need)) ||
          (viol_r && (s.remote_cnt + 3'h1 >= need))) begin
        next_s.alert = 1'b1;
        next_s.high_cause = lh | rh;
      end
      if (diode_fault) begin
        next_s.alert = 1'b1;
      end
    end

    // Alert response command.
    next_s.alert_ack = 1'b0;
    if (alert_cmd && !s.ctrl[ctrl_select_bit] && !s.ctrl[ctrl_mask_bit]
        && s.alert) begin
      next_s.alert_ack = 1'b1;
      next_s.addr_byte = {slave_addr, s.high_cause};
      next_s.pend = 1'b1;
    end
    if (arb_lost) begin
      next_s.pend = 1'b0;
    end
    if (alert_cmd_end && s.pend && !arb_lost) begin
      next_s.pend = 1'b0;
      // Release only when the cause is gone and status was cleared.
      if (s.status == '0 && s.local_cnt == 3'h0 && s.remote_cnt == 3'h0
          && !diode_fault) begin
        next_s.alert = 1'b0;
      end
    end

    // AXI4-Lite write path.
    if (awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    do_write = s.aw_held && s.w_held && !s.bvalid;
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = resp_okay;
      unique case (s.aw_addr)
        reg_ctrl: next_s.ctrl = merge(s.ctrl, s.w_data, s.w_strb);
        reg_status: begin
          // Write one to clear; a set in the same cycle wins.
          if (s.w_strb[0]) begin
            next_s.status = (s.status & ~s.w_data[st_width-1:0])
                            | st_set;
          end
        end
        reg_mask: if (s.w_strb[0]) next_s.mask = s.w_data[st_width-1:0];
        reg_local_high:
          next_s.local_high = merge(s.local_high, s.w_data, s.w_strb);
        reg_local_low:
          next_s.local_low = merge(s.local_low, s.w_data, s.w_strb);
        reg_remote_high:
          next_s.remote_high = merge(s.remote_high, s.w_data, s.w_strb);
        reg_remote_low:
          next_s.remote_low = merge(s.remote_low, s.w_data, s.w_strb);
        reg_local_crit:
          next_s.local_crit = merge(s.local_crit, s.w_data, s.w_strb);
        reg_remote_crit:
          next_s.remote_crit = merge(s.remote_crit, s.w_data, s.w_strb);
        reg_hysteresis: next_s.hyst = merge(s.hyst, s.w_data, s.w_strb);
        reg_consecutive: if (s.w_strb[0]) next_s.consec = s.w_data[1:0];
        default: next_s.bresp = resp_slverr;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // AXI4-Lite read path.
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = resp_okay;
      next_s.rdata = 32'h0;
      unique case (araddr)
        reg_ctrl:        next_s.rdata[7:0] = s.ctrl;
        reg_status:      next_s.rdata[st_width-1:0] = s.status;
        reg_mask:        next_s.rdata[st_width-1:0] = s.mask;
        reg_local_high:  next_s.rdata[7:0] = s.local_high;
        reg_local_low:   next_s.rdata[7:0] = s.local_low;
        reg_remote_high: next_s.rdata[7:0] = s.remote_high;
        reg_remote_low:  next_s.rdata[7:0] = s.remote_low;
        reg_local_crit:  next_s.rdata[7:0] = s.local_crit;
        reg_remote_crit: next_s.rdata[7:0] = s.remote_crit;
        reg_hysteresis:  next_s.rdata[7:0] = s.hyst;
        reg_consecutive: next_s.rdata[1:0] = s.consec;
        reg_alert_resp:  next_s.rdata[7:0] = s.addr_byte;
        reg_results:     next_s.rdata[15:0] = {s.remote_res, s.local_res};
        reg_pins: next_s.rdata[4:0] = {s.sec_sync[1], s.crit_sync[1],
                                       s.alert, s.crit2, s.crit};
        default:         next_s.rresp = resp_slverr;
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    next_s.irq = |(next_s.status & s.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.ctrl <= ctrl_reset;
      s.local_high <= high_reset;
      s.remote_high <= high_reset;
      s.local_low <= low_reset;
      s.remote_low <= low_reset;
      s.local_crit <= crit_reset;
      s.remote_crit <= crit_reset;
      s.hyst <= hyst_reset;
      s.consec <= consec_reset;
      s.crit_sync <= 2'h3;
      s.sec_sync <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops of the state, except the second pin, which is muxed and gated by ctrl.
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign alert_ack = s.alert_ack;
  assign alert_addr_byte = s.addr_byte;
  assign critical_alarm_out_oe = s.crit;
  // Second pin: alert unless masked, or second critical alarm.
  assign second_alarm_pin_oe = s.ctrl[ctrl_select_bit] ? s.crit2
                             : (s.alert & !s.ctrl[ctrl_mask_bit]);
  assign irq = s.irq;

endmodule

// file: temp_alarm_pkg.sv
// Purpose: Shared constants for the temperature alarm logic.
// Assumes: Registers reached over AXI4-Lite, 32-bit data, one word each.
// Notes:   All temperatures are signed 8-bit whole degrees.
package temp_alarm_pkg;
  localparam logic [7:0] reg_ctrl         = 8'h00;
  localparam logic [7:0] reg_status       = 8'h04;
  localparam logic [7:0] reg_mask         = 8'h08;
  localparam logic [7:0] reg_local_high   = 8'h0c;
  localparam logic [7:0] reg_local_low    = 8'h10;
  localparam logic [7:0] reg_remote_high  = 8'h14;
  localparam logic [7:0] reg_remote_low   = 8'h18;
  localparam logic [7:0] reg_local_crit   = 8'h1c;
  localparam logic [7:0] reg_remote_crit  = 8'h20;
  localparam logic [7:0] reg_hysteresis   = 8'h24;
  localparam logic [7:0] reg_consecutive  = 8'h28;
  localparam logic [7:0] reg_alert_resp   = 8'h2c;
  localparam logic [7:0] reg_results      = 8'h30;
  localparam logic [7:0] reg_pins         = 8'h34;
  localparam int ctrl_select_bit = 5;
  localparam int ctrl_mask_bit   = 7;
  localparam int st_local_high  = 0;
  localparam int st_local_low   = 1;
  localparam int st_open_diode  = 2;
  localparam int st_remote_high = 3;
  localparam int st_remote_low  = 4;
  localparam int st_crit        = 5;
  localparam int st_width       = 6;
  localparam logic [7:0] ctrl_reset       = 8'h00;
  localparam logic [7:0] high_reset       = 8'h55;
  localparam logic [7:0] low_reset        = 8'h00;
  localparam logic [7:0] crit_reset       = 8'h55;
  localparam logic [7:0] hyst_reset       = 8'h0a;
  localparam logic [1:0] consec_reset     = 2'h0;
  localparam logic [6:0] slave_addr_reset = 7'h4c;
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// file: temp_alarm_checker.sv
// Purpose: Port assertions for the temperature alarm logic.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every temp_alarm instance.
`timescale 1ns/100ps
module temp_alarm_checker
  import temp_alarm_pkg::*;
#(
  parameter logic [6:0] slave_addr = slave_addr_reset
) (
  // Clock, reset and read channel.
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Conversion and alert response.
  input wire logic        conv_done,
  input wire logic        alert_cmd,
  input wire logic        arb_lost,
  input wire logic        alert_cmd_end,
  input wire logic        alert_ack,
  input wire logic [7:0]  alert_addr_byte,
  // Alarm pins.
  input wire logic        critical_alarm_out_oe,
  input wire logic        second_alarm_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ack_cause_a: assert property (
    alert_ack |-> $past(alert_cmd))
    else $error("Ack came without a command.");
  ack_active_a: assert property (
    alert_ack |-> $past(second_alarm_pin_oe))
    else $error("Ack came while the alert was inactive.");
  ack_pulse_a: assert property (
    alert_ack |=> !alert_ack)
    else $error("Ack lasted more than one cycle.");
  ack_addr_a: assert property (
    alert_ack |-> alert_addr_byte[7:1] == slave_addr)
    else $error("Ack returned a wrong address.");
  lost_keeps_a: assert property (
    alert_cmd_end && arb_lost && second_alarm_pin_oe && !conv_done
    |=> second_alarm_pin_oe)
    else $error("Alert released after lost arbitration.");
  crit_conv_a: assert property (
    !$stable(critical_alarm_out_oe) |-> $past(conv_done))
    else $error("Critical alarm moved without a conversion.");
  read_answer_a: assert property (
    arvalid && arready |=> rvalid)
    else $error("Read data did not follow the address.");
  rdata_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped before taken.");
  cover property (alert_ack);
  cover property (alert_cmd_end && arb_lost);
  cover property ($rose(critical_alarm_out_oe));
endmodule

bind temp_alarm temp_alarm_checker #(.slave_addr(slave_addr)) chk (
  .aclk, .aresetn, .arvalid, .arready, .rvalid, .rready, .rdata,
  .conv_done, .alert_cmd, .arb_lost, .alert_cmd_end, .alert_ack,
  .alert_addr_byte, .critical_alarm_out_oe, .second_alarm_pin_oe
);

// file: smbus_host_model.sv
// Purpose: Host side of the alert line and alert response command.
// Assumes: Pull-ups on both alarm pins.
// Notes:   A gap argument makes the command end promptly or slowly.
`timescale 1ns/100ps
module smbus_host_model (
  // Clock and device outputs.
  input  wire logic       aclk,
  input  wire logic       critical_alarm_out_oe,
  input  wire logic       second_alarm_pin_oe,
  input  wire logic       alert_ack,
  input  wire logic [7:0] alert_addr_byte,
  // Bus engine events and pin levels.
  output logic            alert_cmd,
  output logic            arb_lost,
  output logic            alert_cmd_end,
  output wire logic       critical_alarm_in,
  output wire logic       second_alarm_pin_in
);
  logic       acked;
  logic [7:0] addr;
  // A released pin is pulled high.
  assign critical_alarm_in = !critical_alarm_out_oe;
  assign second_alarm_pin_in = !second_alarm_pin_oe;
  initial begin
    alert_cmd = 1'b0;
    arb_lost = 1'b0;
    alert_cmd_end = 1'b0;
  end
  task automatic respond(input logic lose, input int gap);
    alert_cmd <= 1'b1;
    @(posedge aclk);
    alert_cmd <= 1'b0;
    @(posedge aclk);
    acked = alert_ack;
    addr = alert_addr_byte;
    repeat (gap) @(posedge aclk);
    arb_lost <= lose;
    alert_cmd_end <= 1'b1;
    @(posedge aclk);
    arb_lost <= 1'b0;
    alert_cmd_end <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// file: temperature_alarm_logic_tb.sv
// Purpose: Self-checking bench for the temperature alarm logic.
// Assumes: 20 MHz aclk, reset held for five cycles.
// Notes:   Scenarios run in order and share alarm state.
`timescale 1ns/100ps
module temperature_alarm_logic_tb_top;
  import temp_alarm_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, alert_ack;
  logic        conv_done, diode_fault, alert_cmd, arb_lost, alert_cmd_end;
  logic        critical_alarm_in, critical_alarm_out_oe;
  logic        second_alarm_pin_in, second_alarm_pin_oe;
  logic [7:0]  awaddr, araddr, local_temp, remote_temp, alert_addr_byte;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          num_errors, n_compared;
  temp_alarm dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .conv_done, .local_temp, .remote_temp,
    .diode_fault, .alert_cmd, .arb_lost, .alert_cmd_end, .alert_ack,
    .alert_addr_byte, .critical_alarm_in, .critical_alarm_out_oe,
    .second_alarm_pin_in, .second_alarm_pin_oe, .irq
  );
  smbus_host_model host (
    .aclk, .critical_alarm_out_oe, .second_alarm_pin_oe, .alert_ack,
    .alert_addr_byte, .alert_cmd, .arb_lost, .alert_cmd_end,
    .critical_alarm_in, .second_alarm_pin_in
  );
  task automatic check(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 40) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      step(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_data = rdata;
    resp = rresp;
  endtask
  task automatic cv(input logic [7:0] l, r, input logic f, logic [1:0] e);
    local_temp <= l;
    remote_temp <= r;
    diode_fault <= f;
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge aclk);
    check({critical_alarm_out_oe, second_alarm_pin_oe}, e);
  endtask
  task automatic ar(input logic lose, input logic [1:0] e);
    host.respond(lose, 2);
    check({host.acked, second_alarm_pin_oe}, e);
  endtask
  task automatic wait_for(input logic [1:0] e);
    int n;
    n = 0;
    while ({irq, second_alarm_pin_oe} !== e) step(n);
    check({irq, second_alarm_pin_oe}, e);
  endtask
  task automatic t_crit;
    rd(reg_hysteresis);
    check(rd_data, 32'h0a);
    rd(8'h38);
    check(resp, resp_slverr);
    wr(8'h38, 32'h0);
    check(resp, resp_slverr);
    cv(8'h55, 8'h14, 1'b0, 2'b11);
    rd(reg_pins);
    check(rd_data, 32'h07);
    cv(8'h4b, 8'h14, 1'b0, 2'b11);
    cv(8'h4a, 8'h14, 1'b0, 2'b01);
    cv(8'h14, 8'h55, 1'b0, 2'b11);
    cv(8'h14, 8'h14, 1'b0, 2'b01);
  endtask
  task automatic t_alert;
    ar(1'b1, 2'b11);
    check(host.addr, {slave_addr_reset, 1'b1});
    ar(1'b0, 2'b11);
    wr(reg_status, 32'h3f);
    ar(1'b0, 2'b10);
    ar(1'b0, 2'b00);
  endtask
  task automatic t_consec;
    wr(reg_local_low, 32'h0a);
    wr(reg_consecutive, 32'h02);
    repeat (2) cv(8'h05, 8'h14, 1'b0, 2'b00);
    cv(8'h1e, 8'h14, 1'b0, 2'b00);
    repeat (2) cv(8'h05, 8'h14, 1'b0, 2'b00);
    cv(8'h05, 8'h14, 1'b0, 2'b01);
    ar(1'b0, 2'b11);
    check(host.addr, {slave_addr_reset, 1'b0});
  endtask
  task automatic t_mask;
    wr(reg_mask, 32'h02);
    wait_for(2'b11);
    wr(reg_ctrl, 32'h80);
    wait_for(2'b10);
    ar(1'b0, 2'b00);
    wr(reg_ctrl, 32'h00);
    wait_for(2'b11);
    cv(8'h1e, 8'h14, 1'b0, 2'b01);
    wr(reg_status, 32'h3f);
    wait_for(2'b01);
    ar(1'b0, 2'b10);
  endtask
  task automatic t_fault;
    cv(8'h14, 8'h28, 1'b0, 2'b00);
    cv(8'h14, 8'h63, 1'b1, 2'b01);
    rd(reg_results);
    check(rd_data[15:0], 16'h2814);
    rd(reg_status);
    check(rd_data[4:2], 3'b001);
  endtask
  task automatic t_crit2;
    wr(reg_ctrl, 32'h20);
    cv(8'h05, 8'h14, 1'b0, 2'b01);
    cv(8'h1e, 8'h14, 1'b0, 2'b00);
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    num_errors = 0;
    n_compared = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {conv_done, diode_fault, awaddr, araddr, wdata} = '0;
    {local_temp, remote_temp} = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_crit();
    t_alert();
    t_consec();
    t_mask();
    t_fault();
    t_crit2();
    test_done();
  end
endmodule
